/* File: design/serial_output_unit.sv */
// Serial output unit: five-bit parallel characters to start-stop line code
//
// Overview of operation
// - Acknowledge strobe loads the five-bit character into the transfer register.
// - Transfer moves to holding only while bit clock stopped, then transfer clears.
// - After the move, character request is enabled again toward the multiplexer.
// - Characters carry five data pulses, start and stop; 7.42 or 7.5 units.
// - Rate adjustable 60 to 100 wpm; 100 wpm gives 100 ms characters.
// - One full character buffered beside the one being sent.
// - Request is the only status; acknowledge drops it and starts sending.
// - Acknowledge without a character sends a blank character.
// - Unanswered request just holds the line marking, no error.
// - Line idles marking; leaves marking only at a start element, a zero data bit or on break.
// - Acknowledge sets the acknowledge latch, which qualifies clock control setting.
// - Clock control sets only with bit clock idle and latch set or test input active.
// - Setting clock control with latch set moves transfer into holding in that one cycle.
// - Setting clock control issues a 19 us start pulse; clock begins even.
// - Bit period is two half-bit delays; clock runs only with control set.
// - Transfer register clears 6 us after the move into holding.
// - Even pulse when clock sets, odd when it clears, never overlapping.
// - Eight clock cycles per character; then clock control clears, clock stops.
// - Serializer gates counter with holding bits and frames start and stop.
// - Test input sets clock control; unit inoperative for traffic meanwhile.
// - Space indicator active whenever the line is spacing or broken.
// - Count 1 start 0, counts 2-6 bits 4..0, stop 1 from 7.
// - Counter reaches eight; eight with odd pulse clears clock control.
`timescale 1ns/1ns

module serial_output_unit
  import serializer_pkg::*;
#(
  parameter int unsigned HALF_BIT_DEFAULT = HALF_BIT_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Multiplexer side
  input  wire char_in_t    char_in,
  input  wire logic        ack_strobe,
  output logic             char_request,
  // Line side and maintenance
  input  wire logic        maintenance_select,
  input  wire logic        break_in,
  output logic             line_keyer_driver,
  output logic             space_indicator
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [1:0]            test_sync_q;
  logic [1:0]            break_sync_q;
  logic [CHAR_BITS-1:0]  xfer_q;
  logic                  xfer_full_q;
  logic [CHAR_BITS-1:0]  hold_q;
  logic                  ack_latch_ff_q;
  logic                  clock_control_ff_q;
  clk_state_t            clk_state_q;
  logic                  phase_q;
  logic [3:0]            count_q;
  logic [RATE_W-1:0]     half_cnt_q;
  logic [10:0]           start_cnt_q;
  logic [10:0]           clr_cnt_q;
  logic                  clr_pend_q;
  logic                  char_request_q;
  logic                  line_q;
  logic                  space_q;
  logic                  short_stop_q;
  logic [RATE_W-1:0]     half_bit_q;
  logic                  aw_held_q;
  logic [3:0]            aw_addr_q;
  logic                  w_held_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic                  awready_q;
  logic                  wready_q;
  logic                  arready_q;

  // ************************************************************
  // Functions
  // ************************************************************
  // Serializer: counter state gated with holding-register bits
  function automatic logic serial_bit(input logic [3:0] cnt, input logic [CHAR_BITS-1:0] bits);
    logic [3:0] idx;
    idx = CNT_LAST_DB - cnt;
    if (cnt == CNT_START) begin
      serial_bit = 1'b0;
    end else if (cnt > CNT_START && cnt <= CNT_LAST_DB) begin
      serial_bit = bits[idx[2:0]];
    end else begin
      serial_bit = 1'b1;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    merge = res;
  endfunction

  // ************************************************************
  // Decoding
  // ************************************************************
  wire logic                 test_s      = test_sync_q[1];
  wire logic                 break_s     = break_sync_q[1];
  wire logic                 clock_idle  = (clk_state_q == CLK_IDLE) && !clock_control_ff_q;
  wire logic                 set_control = clock_idle && (ack_latch_ff_q || test_s);
  wire logic                 do_move     = clock_idle && ack_latch_ff_q;
  wire logic                 ack_take    = ack_strobe && !test_s;
  wire logic                 half_done   = (half_cnt_q == '0);
  wire logic                 even_pulse  = (clk_state_q == CLK_START && start_cnt_q == '0) ||
                                           (clk_state_q == CLK_RUN && half_done && !phase_q);
  wire logic                 odd_pulse   = clk_state_q == CLK_RUN && half_done && phase_q;
  wire logic                 last_odd    = odd_pulse && count_q == CNT_END;
  wire logic [RATE_W+5:0]    short_prod  = {6'h00, half_bit_q} * (RATE_W+6)'(SHORT_NUM);
  wire logic [RATE_W-1:0]    short_half  = RATE_W'(short_prod / (RATE_W+6)'(SHORT_DEN));
  wire logic [3:0]           next_count  = count_q + 4'h1;
  wire logic [RATE_W-1:0]    even_load   = (short_stop_q && next_count == CNT_END) ? short_half : half_bit_q;
  wire logic                 next_line   = !break_s && serial_bit(count_q, hold_q);
  // Readies are registered from next state so every bus output leaves a flip-flop
  wire logic                 aw_ready    = awready_q;
  wire logic                 w_ready     = wready_q;
  wire logic                 do_write    = aw_held_q && w_held_q && !bvalid_q;
  wire logic                 ar_ready    = arready_q;
  wire logic                 aw_held_d   = !do_write && (aw_held_q || (s_axi_awvalid && aw_ready));
  wire logic                 w_held_d    = !do_write && (w_held_q || (s_axi_wvalid && w_ready));
  wire logic                 bvalid_d    = do_write || (bvalid_q && !s_axi_bready);
  wire logic                 rvalid_d    = (s_axi_arvalid && ar_ready) || (rvalid_q && !s_axi_rready);
  wire logic                 wr_ctrl     = aw_addr_q == ADDR_CTRL;
  wire logic                 wr_half     = aw_addr_q == ADDR_HALF_BIT;
  wire logic [31:0]          ctrl_word   = {31'h00000000, short_stop_q};
  wire logic [31:0]          half_word   = {{(32-RATE_W){1'b0}}, half_bit_q};
  wire logic [31:0]          ctrl_new    = merge(ctrl_word, w_data_q, w_strb_q);
  wire logic [31:0]          half_new    = merge(half_word, w_data_q, w_strb_q);
  wire status_t              status      = '{count: count_q, brk: break_s, test: test_s,
                                             line_mark: line_q, xfer_full: xfer_full_q,
                                             clock_run: clk_state_q != CLK_IDLE,
                                             clock_control: clock_control_ff_q,
                                             ack_latch: ack_latch_ff_q, char_request: char_request_q};

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_sync_q  <= 2'h0;
      break_sync_q <= 2'h0;
    end else if (clk_en) begin
      test_sync_q  <= {test_sync_q[0], maintenance_select};
      break_sync_q <= {break_sync_q[0], break_in};
    end
  end

  // ************************************************************
  // Transfer, holding and register control
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_q         <= '0;
      xfer_full_q    <= 1'b0;
      hold_q         <= '0;
      ack_latch_ff_q <= 1'b0;
      char_request_q <= 1'b1;
      clr_pend_q     <= 1'b0;
      clr_cnt_q      <= '0;
    end else if (clk_en) begin
      if (ack_take) begin
        // Missing character goes out as blank
        xfer_q         <= char_in.present ? char_in.bits : '0;
        xfer_full_q    <= 1'b1;
        ack_latch_ff_q <= 1'b1;
        char_request_q <= 1'b0;
      end else if (do_move) begin
        hold_q         <= xfer_q;
        ack_latch_ff_q <= 1'b0;
        clr_pend_q     <= 1'b1;
        clr_cnt_q      <= 11'(CLEAR_DELAY_CYC - 1);
      end else if (clr_pend_q) begin
        if (clr_cnt_q == '0) begin
          xfer_q         <= '0;
          xfer_full_q    <= 1'b0;
          clr_pend_q     <= 1'b0;
          // Request waits for the clear so a new character cannot be wiped
          char_request_q <= !test_s;
        end else begin
          clr_cnt_q <= clr_cnt_q - 11'h001;
        end
      end else if (!xfer_full_q && !ack_latch_ff_q) begin
        char_request_q <= !test_s;
      end
    end
  end

  // ************************************************************
  // Clock control, bit clock and counter
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_control_ff_q <= 1'b0;
      clk_state_q        <= CLK_IDLE;
      phase_q            <= 1'b0;
      count_q            <= 4'h0;
      half_cnt_q         <= '0;
      start_cnt_q        <= '0;
    end else if (clk_en) begin
      unique case (clk_state_q)
        CLK_IDLE: begin
          if (set_control) begin
            clock_control_ff_q <= 1'b1;
            clk_state_q        <= CLK_START;
            start_cnt_q        <= 11'(START_PULSE_CYC - 1);
          end
        end
        CLK_START: begin
          if (even_pulse) begin
            clk_state_q <= CLK_RUN;
            phase_q     <= 1'b1;
            count_q     <= next_count;
            half_cnt_q  <= half_bit_q - 1'b1;
          end else begin
            start_cnt_q <= start_cnt_q - 11'h001;
          end
        end
        CLK_RUN: begin
          if (last_odd) begin
            clock_control_ff_q <= 1'b0;
            clk_state_q        <= CLK_IDLE;
            phase_q            <= 1'b0;
            count_q            <= 4'h0;
          end else if (odd_pulse) begin
            phase_q    <= 1'b0;
            half_cnt_q <= half_bit_q - 1'b1;
          end else if (even_pulse) begin
            phase_q    <= 1'b1;
            count_q    <= next_count;
            half_cnt_q <= even_load - 1'b1;
          end else begin
            half_cnt_q <= half_cnt_q - 1'b1;
          end
        end
        default: begin
          clk_state_q <= CLK_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Line keying
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_q  <= 1'b1;
      space_q <= 1'b0;
    end else if (clk_en) begin
      line_q  <= next_line;
      space_q <= !next_line;
    end
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q    <= 1'b0;
      aw_addr_q    <= 4'h0;
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      bvalid_q     <= 1'b0;
      bresp_q      <= RESP_OKAY;
      short_stop_q <= 1'b0;
      half_bit_q   <= RATE_W'(HALF_BIT_DEFAULT);
      awready_q    <= 1'b1;
      wready_q     <= 1'b1;
    end else if (clk_en) begin
      awready_q <= !aw_held_d && !bvalid_d;
      wready_q  <= !w_held_d && !bvalid_d;
      if (s_axi_awvalid && aw_ready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && w_ready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_ctrl || wr_half) ? RESP_OKAY : RESP_SLVERR;
        if (wr_ctrl) begin
          short_stop_q <= ctrl_new[CTRL_SHORT_POS];
        end
        if (wr_half && half_new[RATE_W-1:0] != '0) begin
          half_bit_q <= half_new[RATE_W-1:0];
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OKAY;
      arready_q <= 1'b1;
    end else if (clk_en) begin
      arready_q <= !rvalid_d;
      if (s_axi_arvalid && ar_ready) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_CTRL:     rdata_q <= ctrl_word;
          ADDR_HALF_BIT: rdata_q <= half_word;
          ADDR_STATUS:   rdata_q <= {{(32-$bits(status_t)){1'b0}}, status};
          default: begin
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;
  assign char_request      = char_request_q;
  assign line_keyer_driver = line_q;
  assign space_indicator   = space_q;

endmodule // serial_output_unit

/* File: design/serializer_pkg.sv */
// Package: constants and carrier types for the serial output unit
package serializer_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned START_PULSE_NS = 19000;
  localparam int unsigned CLEAR_DELAY_NS = 6000;
  localparam int unsigned START_PULSE_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_DELAY_CYC = (CLEAR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // 100 wpm: 100 ms per 7.5-unit character, half a unit per delay
  localparam int unsigned CHAR_TIME_NS    = 100000000;
  localparam int unsigned HALF_BIT_CYC    = CHAR_TIME_NS / CLK_PERIOD_NS / 15;

  // ************************************************************
  // Character format
  // ************************************************************
  localparam int unsigned CHAR_BITS   = 5;
  localparam logic [3:0]  CNT_START   = 4'h1;
  localparam logic [3:0]  CNT_LAST_DB = 4'h6;
  localparam logic [3:0]  CNT_END     = 4'h8;
  // Short stop: final half of 0.42 unit instead of 0.5 (ratio 21/25)
  localparam int unsigned SHORT_NUM   = 21;
  localparam int unsigned SHORT_DEN   = 25;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned RATE_W        = 24;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_HALF_BIT = 4'h4;
  localparam logic [3:0]  ADDR_STATUS   = 4'h8;
  localparam int unsigned CTRL_SHORT_POS = 0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic                 present;
    logic [CHAR_BITS-1:0] bits;
  } char_in_t;

  typedef struct packed {
    logic [3:0] count;
    logic       brk;
    logic       test;
    logic       line_mark;
    logic       xfer_full;
    logic       clock_run;
    logic       clock_control;
    logic       ack_latch;
    logic       char_request;
  } status_t;

  typedef enum logic [1:0] {
    CLK_IDLE  = 2'b00,
    CLK_START = 2'b01,
    CLK_RUN   = 2'b10
  } clk_state_t;

endpackage

/* File: sim/serial_output_unit_properties.sv */
// Checker: port-level properties of the serial output unit
`timescale 1ns/1ns
module serial_output_unit_properties
  import serializer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ack_strobe,
  input wire logic char_request,
  input wire logic maintenance_select,
  input wire logic break_in,
  input wire logic line_keyer_driver,
  input wire logic space_indicator
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturates so a long test-mode stretch cannot wrap it
  logic [11:0] low_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || char_request) low_cnt_q <= 12'h000;
    else if (low_cnt_q != 12'hFFF) low_cnt_q <= low_cnt_q + 12'h001;
  end
  // ********************
  // Properties
  // ********************
  a_space_mirror: assert property (space_indicator == !line_keyer_driver)
    else $error("space indicator disagrees with line");
  a_break_spacing: assert property (break_in [*5] |-> !line_keyer_driver)
    else $error("break did not open the line");
  a_ack_drops_req: assert property ((!maintenance_select) [*3] ##0 ack_strobe |=> !char_request)
    else $error("request stayed up after acknowledge");
  a_req_hold: assert property ($rose(char_request) |-> low_cnt_q >= CLEAR_DELAY_CYC)
    else $error("request returned before transfer clear");
  a_test_no_req: assert property (maintenance_select [*6] |-> !char_request)
    else $error("request raised in test");
  a_start_width: assert property ($fell(line_keyer_driver) && !break_in |-> !line_keyer_driver [*8])
    else $error("line spaced for less than an element");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule // serial_output_unit_properties

/* File: sim/mux_channel_model.sv */
// Partner model: output multiplexer channel answering character requests
`timescale 1ns/1ns
module mux_channel_model
  import serializer_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       char_request,
  input  wire logic       enable,
  input  wire logic [7:0] wait_cyc,
  input  wire logic [4:0] chr,
  input  wire logic       with_data,
  output char_in_t        char_in,
  output logic            ack_strobe
);
  logic [7:0] cnt_q;
  logic       armed_q;
  // Idle data lines carry the inverse character so a stray load shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q      <= 8'h00;
      armed_q    <= 1'b1;
      ack_strobe <= 1'b0;
      char_in    <= '{present: 1'b0, bits: ~chr};
    end else if (!char_request) begin
      armed_q    <= 1'b1;
      ack_strobe <= 1'b0;
      char_in    <= '{present: 1'b0, bits: ~chr};
    end else if (enable && armed_q && cnt_q == wait_cyc) begin
      ack_strobe <= 1'b1;
      char_in    <= '{present: with_data, bits: with_data ? chr : ~chr};
      armed_q    <= 1'b0;
      cnt_q      <= 8'h00;
    end else begin
      ack_strobe <= 1'b0;
      char_in    <= '{present: 1'b0, bits: ~chr};
      if (enable && armed_q) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // mux_channel_model

/* File: sim/serial_output_unit_test.sv */
// Bench for the serial output unit: bus tasks, character sends, line capture
`timescale 1ns/1ns
bind serial_output_unit serial_output_unit_properties u_serial_output_unit_properties (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .ack_strobe, .char_request, .maintenance_select, .break_in,
  .line_keyer_driver, .space_indicator);
module serial_output_unit_test
  import serializer_pkg::*;
;
  localparam int unsigned H = 25;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, maintenance_select = 1'b0, break_in = 1'b0;
  logic        m_en = 1'b0, m_pres = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [4:0]  m_chr = 5'h00;
  logic [7:0]  m_wait = 8'h00;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ack_strobe;
  logic        char_request, line_keyer_driver, space_indicator;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  char_in_t    char_in;
  logic [6:0]  frame;
  int          num_errors = 0, n_tests = 0, g0, g1;
  always #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  serial_output_unit #(.HALF_BIT_DEFAULT(H)) u_serial_output_unit (.aclk, .aresetn, .clk_en(1'b1),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .char_in, .ack_strobe,
    .char_request, .maintenance_select, .break_in, .line_keyer_driver, .space_indicator);
  mux_channel_model u_mux_channel_model (.aclk, .aresetn, .char_request, .enable(m_en),
    .wait_cyc(m_wait), .chr(m_chr), .with_data(m_pres), .char_in, .ack_strobe);
  // ********************
  // Tasks
  // ********************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Ready and valid are looked at on the falling edge, where the next rising edge will see them
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      n++;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check(32'(r), 32'(er), "write response");
  endtask
  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] rd;
    logic [1:0] rr;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr && n < 100) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      n++;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(rd, ed, "read data");
    check(32'(rr), 32'(er), "read response");
  endtask
  task automatic send(input logic [4:0] c, input logic p, input logic [7:0] w);
    int n;
    n = 0;
    @(posedge aclk);
    m_chr <= c;
    m_pres <= p;
    m_wait <= w;
    m_en <= 1'b1;
    while (ack_strobe !== 1'b1 && n < 3000) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    m_en <= 1'b0;
    @(negedge aclk);
    check(32'(char_request), 32'h0, "request after acknowledge");
  endtask
  // Samples each element at its middle, two half-bit delays apart
  task automatic get_char(output logic [6:0] f);
    int n;
    n = 0;
    while (line_keyer_driver !== 1'b0 && n < 5000) begin
      @(negedge aclk);
      n++;
    end
    repeat (H) @(negedge aclk);
    for (int i = 6; i >= 0; i--) begin
      f[i] = line_keyer_driver;
      repeat (2 * H) @(negedge aclk);
    end
  endtask
  // Start-to-start spacing; only meaningful while a blank repeats in test
  task automatic gap(output int g);
    g = 0;
    while (line_keyer_driver !== 1'b0 && g < 9000) begin @(negedge aclk); g++; end
    g = 0;
    while (line_keyer_driver === 1'b0 && g < 9000) begin @(negedge aclk); g++; end
    while (line_keyer_driver === 1'b1 && g < 9000) begin @(negedge aclk); g++; end
  endtask
  // ********************
  // Sequence
  // ********************
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ADDR_STATUS, 32'h0000_0021, RESP_OKAY);
    axi_read(ADDR_HALF_BIT, 32'(H), RESP_OKAY);
    axi_write(ADDR_HALF_BIT, 32'h0, RESP_OKAY);
    axi_read(ADDR_HALF_BIT, 32'(H), RESP_OKAY);
    axi_write(4'hC, 32'h1, RESP_SLVERR);
    axi_read(4'hC, 32'h0, RESP_SLVERR);
    repeat (300) @(negedge aclk);
    check(32'({line_keyer_driver, char_request}), 32'h3, "idle line");
    send(5'h16, 1'b1, 8'h00);
    for (int i = 0; i < 700 && char_request !== 1'b1; i++) @(negedge aclk);
    check(32'(char_request), 32'h1, "request after move");
    send(5'h09, 1'b1, 8'hC8);
    get_char(frame);
    check(32'(frame), 32'({1'b0, 5'h16, 1'b1}), "first frame");
    get_char(frame);
    check(32'(frame), 32'({1'b0, 5'h09, 1'b1}), "buffered frame");
    send(5'h1B, 1'b0, 8'h00);
    get_char(frame);
    check(32'(frame), 32'h01, "blank frame");
    @(posedge aclk);
    break_in <= 1'b1;
    repeat (7) @(negedge aclk);
    check(32'({space_indicator, line_keyer_driver}), 32'h2, "line in break");
    @(posedge aclk);
    break_in <= 1'b0;
    repeat (6) @(negedge aclk);
    check(32'({space_indicator, line_keyer_driver}), 32'h1, "line after break");
    @(posedge aclk);
    maintenance_select <= 1'b1;
    gap(g0);
    gap(g0);
    check(32'(g0 >= 15 * H), 32'h1, "test mode characters");
    check(32'(g0), 32'(15 * H + START_PULSE_CYC + 1), "test mode period");
    axi_write(ADDR_CTRL, 32'h1, RESP_OKAY);
    gap(g1);
    gap(g1);
    check(32'(g0 - g1), 32'h4, "short stop saving");
    @(posedge aclk);
    maintenance_select <= 1'b0;
    wrap_up();
  end
endmodule // serial_output_unit_test
